// File: design/drmc_pkg.sv
package drmc_pkg;
  // register byte addresses
  localparam logic [7:0] ADDR_MARGIN_LO = 8'h00;
  localparam logic [7:0] ADDR_MARGIN_HI = 8'h04;
  localparam logic [7:0] ADDR_NOMINAL   = 8'h08;
  localparam logic [7:0] ADDR_WINDOW    = 8'h0C;
  localparam logic [7:0] ADDR_STATUS    = 8'h10;
  localparam logic [7:0] ADDR_REF_CFG   = 8'h14;
  localparam logic [7:0] ADDR_MODE      = 8'h18;
  localparam logic [7:0] ADDR_FREQ      = 8'h1C;
  localparam logic [7:0] ADDR_LOOP_STS  = 8'h20;
  // field widths and positions
  localparam int CNT_W          = 22;
  localparam int DIV_W          = 19;
  localparam int FAIL_MASK_BIT  = 20;
  localparam int REF_MODE_LSB   = 6;
  localparam int REF_MAN_BIT    = 4;
  localparam int REVERT_BIT     = 1;
  localparam int HITLESS_BIT    = 0;
  localparam int ACQ_SWAP_BIT   = 7;
  localparam int LOSS_FREE_BIT  = 6;
  localparam int FILT_DIS_BIT   = 3;
  localparam int ENABLE_BIT     = 2;
  // encodings and reset values
  localparam logic [1:0] REF_MODE_MANUAL = 2'h0;
  localparam logic [1:0] REF_MODE_AUTO   = 2'h2;
  localparam logic [1:0] ST_FREERUN      = 2'h0;
  localparam logic [1:0] ST_NORMAL       = 2'h1;
  localparam logic [1:0] ST_HOLDOVER     = 2'h2;
  localparam logic [1:0] ST_WRITE_FREQ   = 2'h3;
  localparam logic [7:0] MODE_RESET      = 8'h81;
  localparam logic [7:0] REF_CFG_RESET   = 8'h00;
  // acquire lasts a fixed number of clocks before normal
  localparam logic [7:0] ACQUIRE_CYCLES  = 8'h3F;
  // window timing, bus responses and loop states
  localparam int WINDOW_MS        = 10;
  localparam int CLOCK_MHZ        = 100;
  localparam int WINDOW_CYCLES    = WINDOW_MS * 1000 * CLOCK_MHZ;
  localparam logic [1:0] AXI_OKAY   = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;
  typedef enum logic [4:0] {
    LS_FREERUN  = 5'h01,
    LS_ACQUIRE  = 5'h02,
    LS_NORMAL   = 5'h04,
    LS_HOLDOVER = 5'h08,
    LS_DCO      = 5'h10
  } drmc_loop_t;
endpackage : drmc_pkg

// File: design/drmc_act_mon.sv
`timescale 1ns/100ps
`default_nettype none
module drmc_act_mon
  import drmc_pkg::*;
#(
  parameter int W = 22
)
(
  // clock and reset
  input  wire logic         i_clock,
  input  wire logic         i_arst_n,
  input  wire logic         i_ce,
  // measured clocks
  input  wire logic         i_ref_tick,
  input  wire logic         i_osc_tick,
  // configuration
  input  wire logic [18:0]  i_div_ratio,
  input  wire logic [W-1:0] i_nominal,
  input  wire logic [W-1:0] i_acc_margin,
  input  wire logic [W-1:0] i_rej_margin,
  // status
  output logic              o_fail
);
  logic [18:0]  div_ff;
  logic [W-1:0] cnt_ff;
  logic         fail_ff;
  wire          win_end = i_ref_tick && (div_ff >= i_div_ratio);
  wire [W:0]    diff    = (cnt_ff >= i_nominal) ? {1'b0, cnt_ff - i_nominal}
                                                : {1'b0, i_nominal - cnt_ff};
  wire          accept  = diff <= {1'b0, i_acc_margin};
  wire          reject  = diff >  {1'b0, i_rej_margin};
  wire          disabled = (i_nominal == '0);
  logic         nxt_fail;
  always_comb
  begin
    nxt_fail = fail_ff;
    if (disabled)
      nxt_fail = 1'b1;
    else if (win_end && reject)
      nxt_fail = 1'b1;
    else if (win_end && accept)
      nxt_fail = 1'b0;
  end
  always_ff @(posedge i_clock or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      div_ff  <= '0;
      cnt_ff  <= '0;
      fail_ff <= 1'b1;
    end
    else if (i_ce)
    begin
      fail_ff <= nxt_fail;
      if (i_ref_tick)
        div_ff <= win_end ? '0 : div_ff + 19'h00001;
      if (win_end)
        cnt_ff <= '0;
      else if (i_osc_tick && cnt_ff != '1)
        cnt_ff <= cnt_ff + 1'b1;
    end
  end
  assign o_fail = fail_ff;
  disabled_fails_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (i_ce && disabled) |=> o_fail)
    else $error("disabled monitor not failing");
  window_clears_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (i_ce && win_end) |=> cnt_ff == '0)
    else $error("counter not cleared at window end");
endmodule : drmc_act_mon
`default_nettype wire

// File: design/drmc_ctrl.sv
// The implementer's own choices: the register offsets and register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
module drmc_ctrl
  import drmc_pkg::*;
(
  // clock, reset, enable
  input  wire logic        i_clock,
  input  wire logic        i_arst_n,
  input  wire logic        i_ce,
  // reference edges (one-cycle pulses) and divided oscillator tick
  input  wire logic        i_input_reference_zero,
  input  wire logic        i_input_reference_one,
  input  wire logic        i_osc_tick,
  // axi4-lite write
  input  wire logic [7:0]  i_awaddr,
  input  wire logic        i_awvalid,
  output logic             o_awready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  output logic [1:0]       o_bresp,
  output logic             o_bvalid,
  input  wire logic        i_bready,
  // axi4-lite read
  input  wire logic [7:0]  i_araddr,
  input  wire logic        i_arvalid,
  output logic             o_arready,
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  output logic             o_rvalid,
  input  wire logic        i_rready,
  // loop control
  output logic             o_ref_sel,
  output logic             o_hitless_switch,
  output logic             o_acquire_filter,
  output logic             o_filter_hold,
  output logic             o_loop_clock_en,
  output logic [4:0]       o_loop_state
);
  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [21:0] acc_ff, rej_ff, nom_ff;
  logic [31:0] win_ff;
  logic [7:0]  ref_cfg_ff, mode_ff;
  logic [31:0] freq_ff;
  logic        freq_wr_ff;
  logic [1:0]  fail_ff;
  // ---------------------------------------------------------------
  // axi write path: address and data latched in either order
  // ---------------------------------------------------------------
  logic        aw_ff, w_ff;
  logic [7:0]  awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0]  wstrb_ff;
  logic        bvalid_ff;
  logic [1:0]  bresp_ff;
  wire do_write = aw_ff && w_ff && !bvalid_ff;
  wire wr_hit   = (awaddr_ff == ADDR_MARGIN_LO) || (awaddr_ff == ADDR_MARGIN_HI) ||
                  (awaddr_ff == ADDR_NOMINAL)   || (awaddr_ff == ADDR_WINDOW)    ||
                  (awaddr_ff == ADDR_REF_CFG)   || (awaddr_ff == ADDR_MODE)      ||
                  (awaddr_ff == ADDR_FREQ);
  wire [31:0] bmask = {{8{wstrb_ff[3]}}, {8{wstrb_ff[2]}}, {8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [31:0] m);
    merge = (old & ~m) | (nw & m);
  endfunction : merge
  wire [31:0] m_lo  = merge({10'h000, rej_ff}, wdata_ff, bmask);
  wire [31:0] m_hi  = merge({10'h000, acc_ff}, wdata_ff, bmask);
  wire [31:0] m_nom = merge({10'h000, nom_ff}, wdata_ff, bmask);
  wire [31:0] m_win = merge(win_ff, wdata_ff, bmask);
  assign o_awready = !aw_ff;
  assign o_wready  = !w_ff;
  assign o_bvalid  = bvalid_ff;
  assign o_bresp   = bresp_ff;
  always_ff @(posedge i_clock or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      aw_ff     <= 1'b0;
      w_ff      <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff  <= AXI_OKAY;
      awaddr_ff <= '0;
      wdata_ff  <= '0;
      wstrb_ff  <= '0;
    end
    else if (i_ce)
    begin
      if (i_awvalid && !aw_ff)
      begin
        aw_ff     <= 1'b1;
        awaddr_ff <= i_awaddr;
      end
      if (i_wvalid && !w_ff)
      begin
        w_ff     <= 1'b1;
        wdata_ff <= i_wdata;
        wstrb_ff <= i_wstrb;
      end
      if (do_write)
      begin
        bvalid_ff <= 1'b1;
        bresp_ff  <= wr_hit ? AXI_OKAY : AXI_SLVERR;
      end
      else if (bvalid_ff && i_bready)
      begin
        bvalid_ff <= 1'b0;
        aw_ff     <= 1'b0;
        w_ff      <= 1'b0;
      end
    end
  end
  always_ff @(posedge i_clock or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      acc_ff     <= '0;
      rej_ff     <= '0;
      nom_ff     <= '0;
      win_ff     <= '0;
      ref_cfg_ff <= REF_CFG_RESET;
      mode_ff    <= MODE_RESET;
      freq_ff    <= '0;
      freq_wr_ff <= 1'b0;
    end
    else if (i_ce)
    begin
      freq_wr_ff <= 1'b0;
      if (do_write)
        case (awaddr_ff)
          ADDR_MARGIN_LO: rej_ff <= m_lo[21:0];
          ADDR_MARGIN_HI: acc_ff <= m_hi[21:0];
          ADDR_NOMINAL:   nom_ff <= m_nom[21:0];
          ADDR_WINDOW:    win_ff <= m_win & 32'h0017FFFF;
          ADDR_REF_CFG:   if (wstrb_ff[0]) ref_cfg_ff <= wdata_ff[7:0] & 8'hD3;
          ADDR_MODE:      if (wstrb_ff[0]) mode_ff <= wdata_ff[7:0];
          ADDR_FREQ:
          begin
            freq_ff    <= merge(freq_ff, wdata_ff, bmask);
            freq_wr_ff <= 1'b1;
          end
          default: ;
        endcase
    end
  end
  // ---------------------------------------------------------------
  // activity monitors, one per reference
  // ---------------------------------------------------------------
  wire [1:0] ref_tick = {i_input_reference_one, i_input_reference_zero};
  for (genvar g = 0; g < 2; g++)
  begin : g_mon
    drmc_act_mon #(.W(CNT_W)) u_mon (
      .i_clock      (i_clock),
      .i_arst_n     (i_arst_n),
      .i_ce         (i_ce),
      .i_ref_tick   (ref_tick[g]),
      .i_osc_tick   (i_osc_tick),
      .i_div_ratio  (win_ff[DIV_W-1:0]),
      .i_nominal    (nom_ff),
      .i_acc_margin (acc_ff),
      .i_rej_margin (rej_ff),
      .o_fail       (fail_ff[g])
    );
  end
  wire       mask   = win_ff[FAIL_MASK_BIT];
  wire [1:0] ref_ok = ~fail_ff | {2{mask}};
  // ---------------------------------------------------------------
  // reference selection
  // ---------------------------------------------------------------
  logic sel_ff;
  wire  auto_mode = ref_cfg_ff[REF_MODE_LSB +: 2] == REF_MODE_AUTO;
  wire  revert    = ref_cfg_ff[REVERT_BIT];
  logic nxt_sel;
  always_comb
  begin
    nxt_sel = sel_ff;
    if (!auto_mode)
      nxt_sel = ref_cfg_ff[REF_MAN_BIT];
    else if (!ref_ok[sel_ff] && ref_ok[~sel_ff])
      nxt_sel = ~sel_ff;
    else if (revert && sel_ff && ref_ok[0])
      nxt_sel = 1'b0;
  end
  // ---------------------------------------------------------------
  // loop state
  // ---------------------------------------------------------------
  drmc_loop_t st_ff, nxt_st;
  logic [7:0] acq_ff;
  wire [1:0]  force_st = mode_ff[1:0];
  wire        cur_ok   = ref_ok[nxt_sel];
  always_comb
  begin
    nxt_st = st_ff;
    case (force_st)
      ST_FREERUN:    nxt_st = LS_FREERUN;
      ST_HOLDOVER:   nxt_st = LS_HOLDOVER;
      ST_WRITE_FREQ: nxt_st = LS_DCO;
      default:
        if (!cur_ok)
          nxt_st = mode_ff[LOSS_FREE_BIT] ? LS_FREERUN : LS_HOLDOVER;
        else
          case (st_ff)
            LS_ACQUIRE: nxt_st = (acq_ff == ACQUIRE_CYCLES) ? LS_NORMAL : LS_ACQUIRE;
            LS_NORMAL:  nxt_st = (nxt_sel != sel_ff) ? LS_ACQUIRE : LS_NORMAL;
            default:    nxt_st = LS_ACQUIRE;
          endcase
    endcase
  end
  always_ff @(posedge i_clock or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      sel_ff <= 1'b0;
      st_ff  <= LS_FREERUN;
      acq_ff <= '0;
    end
    else if (i_ce)
    begin
      sel_ff <= nxt_sel;
      st_ff  <= nxt_st;
      acq_ff <= (nxt_st == LS_ACQUIRE && st_ff == LS_ACQUIRE) ? acq_ff + 8'h01 : 8'h00;
    end
  end
  assign o_ref_sel        = sel_ff;
  assign o_loop_state     = st_ff;
  assign o_hitless_switch = ref_cfg_ff[HITLESS_BIT];
  assign o_acquire_filter = mode_ff[ACQ_SWAP_BIT] && st_ff == LS_ACQUIRE;
  assign o_filter_hold    = mode_ff[FILT_DIS_BIT] || freq_wr_ff;
  assign o_loop_clock_en  = mode_ff[ENABLE_BIT];
  // ---------------------------------------------------------------
  // axi read path
  // ---------------------------------------------------------------
  logic        rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0]  rresp_ff;
  wire [31:0]  rd_mux =
      (i_araddr == ADDR_MARGIN_LO) ? {10'h000, rej_ff} :
      (i_araddr == ADDR_MARGIN_HI) ? {10'h000, acc_ff} :
      (i_araddr == ADDR_NOMINAL)   ? {10'h000, nom_ff} :
      (i_araddr == ADDR_WINDOW)    ? win_ff :
      (i_araddr == ADDR_STATUS)    ? {30'h0, fail_ff} :
      (i_araddr == ADDR_REF_CFG)   ? {24'h0, ref_cfg_ff} :
      (i_araddr == ADDR_MODE)      ? {24'h0, mode_ff} :
      (i_araddr == ADDR_FREQ)      ? freq_ff :
      (i_araddr == ADDR_LOOP_STS)  ? {26'h0, st_ff, sel_ff} : 32'h0;
  wire rd_hit = (i_araddr <= ADDR_LOOP_STS) && (i_araddr[1:0] == 2'h0);
  assign o_arready = !rvalid_ff;
  assign o_rvalid  = rvalid_ff;
  assign o_rdata   = rdata_ff;
  assign o_rresp   = rresp_ff;
  always_ff @(posedge i_clock or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= '0;
      rresp_ff  <= AXI_OKAY;
    end
    else if (i_ce)
    begin
      if (i_arvalid && !rvalid_ff)
      begin
        rvalid_ff <= 1'b1;
        rdata_ff  <= rd_hit ? rd_mux : 32'h0;
        rresp_ff  <= rd_hit ? AXI_OKAY : AXI_SLVERR;
      end
      else if (rvalid_ff && i_rready)
        rvalid_ff <= 1'b0;
    end
  end
  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  manual_select_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (i_ce && !auto_mode) |=> o_ref_sel == $past(ref_cfg_ff[REF_MAN_BIT]))
    else $error("manual select not followed");
  loss_state_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (i_ce && force_st == ST_NORMAL && !cur_ok) |=>
      o_loop_state == ($past(mode_ff[LOSS_FREE_BIT]) ? LS_FREERUN : LS_HOLDOVER))
    else $error("wrong state on reference loss");
  forced_state_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (i_ce && force_st == ST_WRITE_FREQ) |=> o_loop_state == LS_DCO)
    else $error("dco mode not forced");
  freq_hold_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (i_ce && do_write && awaddr_ff == ADDR_FREQ) |=> o_filter_hold)
    else $error("frequency write did not hold filter");
  mask_ok_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (i_ce && mask && force_st == ST_NORMAL) |=>
      (o_loop_state == LS_ACQUIRE || o_loop_state == LS_NORMAL))
    else $error("masked reference not qualified");
  acquire_filter_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    !mode_ff[ACQ_SWAP_BIT] |-> !o_acquire_filter)
    else $error("locking filter used while swap off");
endmodule : drmc_ctrl
`default_nettype wire

// File: verification/drmc_ref_model.sv
`timescale 1ns/100ps
`default_nettype none
// ----
// two reference clocks plus divided oscillator
// ----
module drmc_ref_model
(
  // clock and reset
  input  wire logic       i_clock,
  input  wire logic       i_arst_n,
  // periods in clocks, never zero
  input  wire logic [7:0] i_period_0,
  input  wire logic [7:0] i_period_1,
  // edges towards the block
  output logic            o_tick_0,
  output logic            o_tick_1,
  output logic            o_osc_tick
);
  logic [7:0] cnt_0_ff;
  logic [7:0] cnt_1_ff;
  // oscillator ticks every clock, so a window counts 4 x period minus one
  assign o_osc_tick = i_arst_n;
  assign o_tick_0   = i_arst_n & (cnt_0_ff == 8'h00);
  assign o_tick_1   = i_arst_n & (cnt_1_ff == 8'h00);
  always_ff @(posedge i_clock or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      cnt_0_ff <= 8'h00;
      cnt_1_ff <= 8'h00;
    end
    else
    begin
      cnt_0_ff <= (cnt_0_ff >= i_period_0 - 8'h01) ? 8'h00 : cnt_0_ff + 8'h01;
      cnt_1_ff <= (cnt_1_ff >= i_period_1 - 8'h01) ? 8'h00 : cnt_1_ff + 8'h01;
    end
  end
endmodule : drmc_ref_model
`default_nettype wire

// File: verification/dpll_mode_ref_qualify_ctrl_tb.sv
`timescale 1ns/100ps
`default_nettype none
module dpll_mode_ref_qualify_ctrl_tb
  import drmc_pkg::*;
();
  logic        i_clock = 1'b0;
  logic        i_arst_n = 1'b0;
  logic [7:0]  i_awaddr = 8'h00;
  logic        i_awvalid = 1'b0;
  logic [31:0] i_wdata = 32'h0;
  logic        i_wvalid = 1'b0;
  logic        i_bready = 1'b0;
  logic [7:0]  i_araddr = 8'h00;
  logic        i_arvalid = 1'b0;
  logic        i_rready = 1'b0;
  logic [7:0]  per_0 = 8'h08;
  logic [7:0]  per_1 = 8'h08;
  logic        t0, t1, osc, awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic        ref_sel, hitless, acq_filt, f_hold, clk_en;
  logic [4:0]  lstate;
  int          hold_count = 0;
  logic [15:0] lfsr = 16'h005D;
  int          fail_count = 0;
  int          checked = 0;
  int          cycles = 0;
  always #5 i_clock = ~i_clock;
  drmc_ref_model i_ref (.i_clock(i_clock), .i_arst_n(i_arst_n), .i_period_0(per_0),
    .i_period_1(per_1), .o_tick_0(t0), .o_tick_1(t1), .o_osc_tick(osc));
  drmc_ctrl i_dut (.i_clock(i_clock), .i_arst_n(i_arst_n), .i_ce(1'b1),
    .i_input_reference_zero(t0), .i_input_reference_one(t1), .i_osc_tick(osc),
    .i_awaddr(i_awaddr), .i_awvalid(i_awvalid), .o_awready(awready), .i_wdata(i_wdata),
    .i_wstrb(4'hF), .i_wvalid(i_wvalid), .o_wready(wready), .o_bresp(bresp),
    .o_bvalid(bvalid), .i_bready(i_bready), .i_araddr(i_araddr), .i_arvalid(i_arvalid),
    .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid),
    .i_rready(i_rready), .o_ref_sel(ref_sel), .o_hitless_switch(hitless),
    .o_acquire_filter(acq_filt), .o_filter_hold(f_hold), .o_loop_clock_en(clk_en),
    .o_loop_state(lstate));
  // ----
  // watchdog and pulse catcher
  // ----
  always @(posedge i_clock)
  begin
    cycles <= cycles + 1;
    if (f_hold)
      hold_count <= hold_count + 1;
    if (cycles == 20000)
    begin
      fail_count++;
      report_and_stop();
    end
  end
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // ----
  // bus master: signals move only just after a rising edge
  // ----
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic pa, pw, ta, tw, v;
    logic [1:0] r;
    @(posedge i_clock);
    i_awaddr  <= a;
    i_wdata   <= d;
    i_awvalid <= 1'b1;
    i_wvalid  <= 1'b1;
    i_bready  <= 1'b1;
    pa = 1'b1;
    pw = 1'b1;
    v = 1'b0;
    while (pa || pw)
    begin
      @(negedge i_clock);
      ta = pa & awready;
      tw = pw & wready;
      @(posedge i_clock);
      pa = pa & ~ta;
      pw = pw & ~tw;
      i_awvalid <= pa;
      i_wvalid  <= pw;
    end
    while (!v)
    begin
      @(negedge i_clock);
      v = bvalid;
      r = bresp;
      @(posedge i_clock);
    end
    i_bready <= 1'b0;
    check($sformatf("bresp@%h", a), {30'h0, er}, {30'h0, r});
  endtask : axw
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic pa, v;
    @(posedge i_clock);
    i_araddr  <= a;
    i_arvalid <= 1'b1;
    i_rready  <= 1'b1;
    pa = 1'b1;
    v = 1'b0;
    while (!v)
    begin
      @(negedge i_clock);
      pa = pa & ~arready;
      v = rvalid;
      d = rdata;
      r = rresp;
      @(posedge i_clock);
      i_arvalid <= pa;
    end
    i_rready <= 1'b0;
  endtask : axr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  r;
    axr(a, d, r);
    check($sformatf("rdata@%h", a), exp, d);
    check($sformatf("rresp@%h", a), {30'h0, er}, {30'h0, r});
  endtask : rd
  task automatic await_sts(input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0]  r;
    int n;
    n = 0;
    do
    begin
      axr(ADDR_STATUS, d, r);
      n++;
    end while (d !== exp && n < 80);
    check("monitor status", exp, d);
  endtask : await_sts
  // k selects the port: 0 loop state, 1 reference select
  task automatic await(input int k, input logic [4:0] exp);
    int n;
    n = 0;
    while ((k == 0 ? lstate : {4'h0, ref_sel}) !== exp && n < 600)
    begin
      @(negedge i_clock);
      n++;
    end
    check(k == 0 ? "loop state" : "ref select", exp, k == 0 ? lstate : {4'h0, ref_sel});
  endtask : await
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : report_and_stop
  // ----
  // main sequence
  // ----
  initial
  begin
    logic [7:0] addrs [3];
    logic [31:0] v;
    int h0;
    addrs = '{ADDR_MARGIN_LO, ADDR_MARGIN_HI, ADDR_NOMINAL};
    repeat (2) @(posedge i_clock);
    i_arst_n <= 1'b1;
    rd(ADDR_MODE, {24'h0, MODE_RESET}, AXI_OKAY);
    rd(ADDR_REF_CFG, 32'h0, AXI_OKAY);
    rd(ADDR_STATUS, 32'h3, AXI_OKAY);
    rd(8'h24, 32'h0, AXI_SLVERR);
    axw(8'h02, 32'h1, AXI_SLVERR);
    for (int k = 0; k < 3; k++)
    begin
      lfsr = lfsr_next(lfsr);
      v = {lfsr, lfsr_next(lfsr)};
      axw(addrs[k], v, AXI_OKAY);
      rd(addrs[k], v & 32'h003FFFFF, AXI_OKAY);
    end
    $display("test registers done");
    // nominal 32: four reference ticks of 8 clocks each
    axw(ADDR_MARGIN_LO, 32'h8, AXI_OKAY);
    axw(ADDR_MARGIN_HI, 32'h2, AXI_OKAY);
    axw(ADDR_NOMINAL, 32'h20, AXI_OKAY);
    axw(ADDR_WINDOW, 32'h3, AXI_OKAY);
    await_sts(32'h0);
    per_1 <= 8'h09;
    repeat (150) @(posedge i_clock);
    rd(ADDR_STATUS, 32'h0, AXI_OKAY);
    per_1 <= 8'h04;
    await_sts(32'h2);
    per_1 <= 8'h08;
    await_sts(32'h0);
    $display("test monitor done");
    // loop is already locked since the monitor test; force freerun so acquire is seen again
    axw(ADDR_MODE, 32'h84, AXI_OKAY);
    axw(ADDR_MODE, 32'h85, AXI_OKAY);
    await(0, LS_ACQUIRE);
    check("acquire filter", 32'h1, {31'h0, acq_filt});
    check("loop clock", 32'h1, {31'h0, clk_en});
    await(0, LS_NORMAL);
    check("acquire filter", 32'h0, {31'h0, acq_filt});
    per_0 <= 8'h04;
    await(0, LS_HOLDOVER);
    per_0 <= 8'h08;
    await(0, LS_NORMAL);
    axw(ADDR_MODE, 32'h04, AXI_OKAY);
    axw(ADDR_MODE, 32'h05, AXI_OKAY);
    await(0, LS_ACQUIRE);
    check("acquire filter", 32'h0, {31'h0, acq_filt});
    axw(ADDR_MODE, 32'hC5, AXI_OKAY);
    per_0 <= 8'h04;
    await(0, LS_FREERUN);
    per_0 <= 8'h08;
    axw(ADDR_MODE, 32'h85, AXI_OKAY);
    await(0, LS_NORMAL);
    // masked before disabling, so the forced failure is ignored
    axw(ADDR_WINDOW, 32'h00100003, AXI_OKAY);
    axw(ADDR_NOMINAL, 32'h0, AXI_OKAY);
    await_sts(32'h3);
    repeat (150) @(posedge i_clock);
    check("loop state", {27'h0, LS_NORMAL}, {27'h0, lstate});
    axw(ADDR_NOMINAL, 32'h20, AXI_OKAY);
    axw(ADDR_WINDOW, 32'h3, AXI_OKAY);
    await_sts(32'h0);
    $display("test loop done");
    axw(ADDR_MODE, 32'h84, AXI_OKAY);
    await(0, LS_FREERUN);
    axw(ADDR_MODE, 32'h86, AXI_OKAY);
    await(0, LS_HOLDOVER);
    axw(ADDR_MODE, 32'h87, AXI_OKAY);
    await(0, LS_DCO);
    rd(ADDR_LOOP_STS, {26'h0, LS_DCO, 1'b0}, AXI_OKAY);
    axw(ADDR_MODE, 32'h81, AXI_OKAY);
    check("loop clock", 32'h0, {31'h0, clk_en});
    axw(ADDR_MODE, 32'h8D, AXI_OKAY);
    check("filter hold", 32'h1, {31'h0, f_hold});
    axw(ADDR_MODE, 32'h85, AXI_OKAY);
    check("filter hold", 32'h0, {31'h0, f_hold});
    h0 = hold_count;
    lfsr = lfsr_next(lfsr);
    axw(ADDR_FREQ, {16'h0, lfsr}, AXI_OKAY);
    // let the pulse counter settle past the edge that ends the hold
    @(negedge i_clock);
    check("hold pulse", 32'h1, hold_count - h0);
    rd(ADDR_FREQ, {16'h0, lfsr}, AXI_OKAY);
    $display("test modes done");
    axw(ADDR_REF_CFG, 32'h10, AXI_OKAY);
    await(1, 5'h01);
    axw(ADDR_REF_CFG, 32'h01, AXI_OKAY);
    await(1, 5'h00);
    check("hitless", 32'h1, {31'h0, hitless});
    axw(ADDR_REF_CFG, 32'h80, AXI_OKAY);
    per_0 <= 8'h04;
    await(1, 5'h01);
    per_0 <= 8'h08;
    repeat (200) @(posedge i_clock);
    check("ref select", 32'h1, {31'h0, ref_sel});
    axw(ADDR_REF_CFG, 32'h82, AXI_OKAY);
    await(1, 5'h00);
    $display("test selection done");
    report_and_stop();
  end
endmodule : dpll_mode_ref_qualify_ctrl_tb
`default_nettype wire
